// ---- verilog/sync_serial_pkg.sv ----
`default_nettype none
package sync_serial_pkg;
   // Bus geometry: register index sits in haddr[ADDR_W-1:2]
   localparam int ADDR_W = 10;
   localparam int IDX_W = ADDR_W - 2;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 8'h0c;
   localparam logic [IDX_W-1:0] IDX_RX_STATUS = 8'h18;
   localparam logic [IDX_W-1:0] IDX_TX_HOLD = 8'h19;
   localparam logic [IDX_W-1:0] IDX_RX_HOLD = 8'h1a;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN = 8'h8c;
   localparam logic [IDX_W-1:0] IDX_TX_STATUS = 8'h98;
   localparam logic [IDX_W-1:0] IDX_RATE = 8'h99;

   // Reset values
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h00;
   localparam logic [7:0] RST_TX_HOLD = 8'h00;

   // Flag and enable register bit positions
   localparam int BIT_PARALLEL = 7;
   localparam int BIT_RX_FLAG = 5;
   localparam int BIT_TX_FLAG = 4;

   // Receive status and control bit positions
   localparam int BIT_SERIAL_PORT_EN = 7;
   localparam int BIT_RX9 = 6;
   localparam int BIT_SINGLE_RX_EN = 5;
   localparam int BIT_CONTINUOUS_RX_EN = 4;
   localparam int BIT_FRAMING_ERROR = 2;
   localparam int BIT_OVERRUN_ERROR = 1;
   localparam int BIT_RX_NINTH_BIT = 0;

   // Transmit status and control bit positions
   localparam int BIT_CLOCK_SOURCE_SEL = 7;
   localparam int BIT_TX9 = 6;
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_SYNC = 4;
   localparam int BIT_BRGH = 2;
   localparam int BIT_SHIFT_EMPTY_FLAG = 1;
   localparam int BIT_TX_NINTH_BIT = 0;

   // Index of the last bit of a word
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic FRAMING_NONE = 1'h0;
endpackage
`default_nettype wire

// ---- verilog/sync_serial_slave.sv ----
// The AHB-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module sync_serial_slave #(
   parameter int RX_FIFO_DEPTH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic shift_clk_pin,
   input wire logic data_pin_in,
   output logic data_pin_out,
   output logic data_pin_oe,
   input wire logic core_sleeping,
   output logic irq_request,
   output logic wake_request
);
   import sync_serial_pkg::*;

   localparam int CNT_W = $clog2(RX_FIFO_DEPTH + 1);
   localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(RX_FIFO_DEPTH);

   // Elaboration check on the receive FIFO depth
   if (RX_FIFO_DEPTH < 1 || RX_FIFO_DEPTH > 8) begin : g_depth_check
      $error("RX_FIFO_DEPTH must lie between 1 and 8");
   end

   function automatic logic reg_at(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] want);
      return idx == want;
   endfunction

   logic dp_valid;
   logic dp_write;
   logic dp_word;
   logic [IDX_W-1:0] dp_index;
   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;
   logic serial_port_en, nine_bit_rx_en, single_rx_en, continuous_rx_en;
   logic clock_source_sel, nine_bit_tx_en, tx_enable, sync_mode, high_rate_sel, tx_ninth_bit;
   logic [7:0] rate_divisor;
   logic [7:0] peripheral_irq_enables;
   logic ck_meta, ck_sync, ck_prev, dt_meta, dt_sync;
   logic ck_fall;
   logic slave_active;
   logic [7:0] tx_holding_reg;
   logic tx_hold_full;
   logic [8:0] tx_shift_reg;
   logic tx_busy;
   logic [3:0] tx_count;
   logic [3:0] tx_last;
   logic tx_run, tx_done, tx_go, tx_flag;
   logic [8:0] rx_shift_reg;
   logic [3:0] rx_count;
   logic [3:0] rx_last;
   logic rx_run, rx_done, rx_push, rx_pop, rx_flag, overrun_error;
   logic [8:0] rx_word;
   logic [8:0] rx_holding_reg [RX_FIFO_DEPTH];
   logic [CNT_W-1:0] rx_level;
   logic [7:0] peripheral_irq_flags;

   // Address phase capture; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_word <= 1'b0;
         dp_index <= '0;
      end else begin
         dp_valid <= hsel & hready & htrans[1] & (haddr[31:ADDR_W] == '0) & (haddr[1:0] == 2'h0);
         dp_write <= hwrite;
         dp_word <= (hsize == HSIZE_WORD);
         dp_index <= haddr[ADDR_W-1:2];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign wr_en = dp_valid & dp_write & dp_word;
   assign rd_en = dp_valid & ~dp_write;
   assign wbyte = hwdata[7:0];

   // Receive control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_port_en <= 1'b0;
         nine_bit_rx_en <= 1'b0;
         single_rx_en <= 1'b0;
         continuous_rx_en <= 1'b0;
      end else if (wr_en && reg_at(dp_index, IDX_RX_STATUS)) begin
         serial_port_en <= wbyte[BIT_SERIAL_PORT_EN];
         nine_bit_rx_en <= wbyte[BIT_RX9];
         single_rx_en <= wbyte[BIT_SINGLE_RX_EN]; // Stored only, no effect
         continuous_rx_en <= wbyte[BIT_CONTINUOUS_RX_EN];
      end
   end

   // Transmit control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_source_sel <= 1'b0;
         nine_bit_tx_en <= 1'b0;
         tx_enable <= 1'b0;
         sync_mode <= 1'b0;
         high_rate_sel <= 1'b0;
         tx_ninth_bit <= 1'b0;
      end else if (wr_en && reg_at(dp_index, IDX_TX_STATUS)) begin
         clock_source_sel <= wbyte[BIT_CLOCK_SOURCE_SEL];
         nine_bit_tx_en <= wbyte[BIT_TX9];
         tx_enable <= wbyte[BIT_TX_ENABLE];
         sync_mode <= wbyte[BIT_SYNC];
         high_rate_sel <= wbyte[BIT_BRGH];
         tx_ninth_bit <= wbyte[BIT_TX_NINTH_BIT];
      end
   end

   // Enables and rate divisor, plain storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         peripheral_irq_enables <= RST_IRQ_EN;
         rate_divisor <= RST_RATE;
      end else if (wr_en) begin
         if (reg_at(dp_index, IDX_IRQ_EN)) begin
            peripheral_irq_enables <= wbyte;
         end
         if (reg_at(dp_index, IDX_RATE)) begin
            rate_divisor <= wbyte;
         end
      end
   end

   // Two-stage synchronisers for the external clock and data pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_meta <= 1'b0;
         ck_sync <= 1'b0;
         ck_prev <= 1'b0;
         dt_meta <= 1'b0;
         dt_sync <= 1'b0;
      end else begin
         ck_meta <= shift_clk_pin;
         ck_sync <= ck_meta;
         ck_prev <= ck_sync;
         dt_meta <= data_pin_in;
         dt_sync <= dt_meta;
      end
   end

   // External clock edge; slave mode means the clock pin is an input
   assign ck_fall = ck_prev & ~ck_sync;
   assign slave_active = serial_port_en & sync_mode & ~clock_source_sel;

   // Transmit sequencing
   assign tx_run = slave_active & tx_enable;
   assign tx_last = nine_bit_tx_en ? LAST_BIT_9 : LAST_BIT_8;
   assign tx_done = tx_busy & ck_fall & (tx_count == tx_last);
   assign tx_go = tx_run & tx_hold_full & (~tx_busy | tx_done);
   assign tx_flag = tx_enable & ~tx_hold_full;

   // Transmit holding register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_holding_reg <= RST_TX_HOLD;
         tx_hold_full <= 1'b0;
      end else if (wr_en && reg_at(dp_index, IDX_TX_HOLD)) begin
         tx_holding_reg <= wbyte;
         tx_hold_full <= 1'b1;
      end else if (tx_go) begin
         tx_hold_full <= 1'b0; // Word moves to the shifter
      end
   end

   // Transmit shifter, LSB first, next bit after each falling edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_shift_reg <= '0;
         tx_busy <= 1'b0;
         tx_count <= '0;
      end else if (!tx_run) begin
         tx_busy <= 1'b0;
         tx_count <= '0;
      end else if (tx_go) begin
         tx_shift_reg <= {tx_ninth_bit, tx_holding_reg}; // Ninth bit taken now
         tx_busy <= 1'b1;
         tx_count <= '0;
      end else if (tx_done) begin
         tx_busy <= 1'b0;
         tx_count <= '0;
      end else if (tx_busy && ck_fall) begin
         tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
         tx_count <= tx_count + 4'h1;
      end
   end

   // Data pin driven only while a word shifts and receive is off
   assign data_pin_out = tx_shift_reg[0];
   assign data_pin_oe = tx_busy & ~continuous_rx_en;

   // Receive sequencing; single-receive enable plays no part
   assign rx_run = slave_active & continuous_rx_en & ~overrun_error;
   assign rx_last = nine_bit_rx_en ? LAST_BIT_9 : LAST_BIT_8;
   assign rx_done = rx_run & ck_fall & (rx_count == rx_last);
   assign rx_word = nine_bit_rx_en ? {dt_sync, rx_shift_reg[8:1]} : {1'b0, dt_sync, rx_shift_reg[8:2]};
   assign rx_push = rx_done & (rx_level != FIFO_FULL);
   assign rx_pop = rd_en & reg_at(dp_index, IDX_RX_HOLD) & (rx_level != '0);
   assign rx_flag = rx_level != '0;

   // Receive shifter, sampling at the falling edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_shift_reg <= '0;
         rx_count <= '0;
      end else if (!rx_run) begin
         rx_count <= '0;
      end else if (ck_fall) begin
         rx_shift_reg <= {dt_sync, rx_shift_reg[8:1]};
         rx_count <= rx_done ? 4'h0 : rx_count + 4'h1;
      end
   end

   // Receive FIFO: head at entry 0, pop shifts down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_level <= '0;
         for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
            rx_holding_reg[i] <= '0;
         end
      end else begin
         rx_level <= CNT_W'(rx_level + CNT_W'(rx_push) - CNT_W'(rx_pop));
         for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
            if (rx_push && (CNT_W'(i) == CNT_W'(rx_level - CNT_W'(rx_pop)))) begin
               rx_holding_reg[i] <= rx_word;
            end else if (rx_pop && (i + 1 < RX_FIFO_DEPTH)) begin
               rx_holding_reg[i] <= rx_holding_reg[(i + 1) % RX_FIFO_DEPTH];
            end
         end
      end
   end

   // Overrun: set on a full FIFO, cleared with continuous receive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun_error <= 1'b0;
      end else if (!continuous_rx_en) begin
         overrun_error <= 1'b0;
      end else if (rx_done && rx_level == FIFO_FULL) begin
         overrun_error <= 1'b1; // Word in shifter discarded
      end
   end

   // Flags; the parallel port flag always reads clear
   always_comb begin
      peripheral_irq_flags = 8'h00;
      peripheral_irq_flags[BIT_PARALLEL] = 1'b0;
      peripheral_irq_flags[BIT_RX_FLAG] = rx_flag;
      peripheral_irq_flags[BIT_TX_FLAG] = tx_flag;
   end

   // Interrupt request and wake from sleep
   assign irq_request = |(peripheral_irq_flags & peripheral_irq_enables
                          & ((8'h01 << BIT_RX_FLAG) | (8'h01 << BIT_TX_FLAG)));
   assign wake_request = core_sleeping & irq_request;

   // Read data mux in the data phase
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_en) begin
         unique case (dp_index)
            IDX_IRQ_FLAGS: hrdata[7:0] = peripheral_irq_flags;
            IDX_RX_STATUS: hrdata[7:0] = {serial_port_en, nine_bit_rx_en, single_rx_en, continuous_rx_en,
                                          1'b0, FRAMING_NONE, overrun_error,
                                          rx_holding_reg[0][8]}; // Head ninth bit
            IDX_RX_HOLD: hrdata[7:0] = rx_holding_reg[0][7:0];
            IDX_IRQ_EN: hrdata[7:0] = peripheral_irq_enables;
            IDX_TX_STATUS: hrdata[7:0] = {clock_source_sel, nine_bit_tx_en, tx_enable, sync_mode,
                                          1'b0, high_rate_sel, ~tx_busy, tx_ninth_bit};
            IDX_RATE: hrdata[7:0] = rate_divisor;
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_tx_hold_flag: assert property (
      (wr_en && reg_at(dp_index, IDX_TX_HOLD) && tx_enable && tx_busy && !tx_done)
      |=> !tx_flag && tx_hold_full)
      else $error("transmit flag set while a word waits in holding");

   chk_tx_reload_flag: assert property (
      (tx_done && tx_hold_full && tx_run && !(wr_en && reg_at(dp_index, IDX_TX_HOLD)))
      |=> tx_busy && tx_flag && (tx_count == 4'h0))
      else $error("second word not reloaded with flag");

   chk_tx_wake_path: assert property (
      (core_sleeping && tx_flag && peripheral_irq_enables[BIT_TX_FLAG]) |-> wake_request)
      else $error("transmit flag did not wake the core");

   chk_rx_single_ignored: assert property (
      (single_rx_en && !continuous_rx_en) |=> (rx_count == 4'h0) && !rx_push)
      else $error("single receive enable started reception");

   chk_rx_word_push: assert property (
      (rx_done && rx_level != FIFO_FULL && !rx_pop)
      |=> rx_level == CNT_W'($past(rx_level) + 1'b1) && rx_flag)
      else $error("completed word not moved to holding");

   chk_rx_irq_wake: assert property (
      (rx_flag && peripheral_irq_enables[BIT_RX_FLAG]) |-> irq_request && (wake_request == core_sleeping))
      else $error("receive flag did not request interrupt");

   chk_overrun_clear: assert property (
      $fell(continuous_rx_en) |=> !overrun_error && (rx_count == 4'h0))
      else $error("overrun not cleared with continuous receive");

   chk_overrun_set: assert property (
      (rx_done && rx_level == FIFO_FULL && !rx_pop && continuous_rx_en)
      |=> overrun_error && (rx_level == FIFO_FULL) ##1 !rx_run)
      else $error("overrun not flagged or transfers not blocked");

   chk_rx_fall_sample: assert property (
      (rx_run && ck_fall && !rx_done) |=> rx_shift_reg[8] == $past(dt_sync))
      else $error("receive bit not sampled at falling edge");

   chk_shift_hold: assert property (
      (!ck_fall && !tx_go) |=> $stable(rx_shift_reg) && $stable(tx_shift_reg))
      else $error("shifter moved without a clock edge");

   cov_tx_reload: cover property (tx_done && tx_hold_full && tx_run);
   cov_rx_two_words: cover property (rx_push ##[1:400] rx_push);
   cov_overrun: cover property (rx_done && rx_level == FIFO_FULL);
   cov_sleep_wake: cover property (core_sleeping && rx_push ##1 wake_request);
endmodule
`default_nettype wire

// ---- tb/serial_master_model.sv ----
`default_nettype none
module serial_master_model (
   output logic shift_clk,
   output logic drive_data,
   input wire logic data_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // Clock stands low between frames
   initial begin
      shift_clk = 1'b0;
      drive_data = 1'b1;
   end

   // One frame, LSB first; the master makes every clock edge
   task automatic xfer(input logic [8:0] tx, input int nbits, output logic [8:0] rx);
      rx = 9'h000;
      #1.3;
      for (int i = 0; i < nbits; i++) begin
         drive_data = tx[i];
         shift_clk = 1'b1;
         #32;
         shift_clk = 1'b0; // Both sides sample at the fall
         rx[i] = data_line;
         #32;
      end
      // Released line shows the inverse of the last bit
      drive_data = ~drive_data;
   endtask
endmodule
`default_nettype wire

// ---- tb/sync_serial_slave_test.sv ----
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module sync_serial_slave_test;
   timeunit 1ns;
   timeprecision 100ps;
   import sync_serial_pkg::*;

   localparam logic [7:0] SERIAL_PORT_EN = 8'h80;
   localparam logic [7:0] SINGLE_RX_EN = 8'h20;
   localparam logic [7:0] CONTINUOUS_RX_EN = 8'h10;
   localparam logic [7:0] SYNC = 8'h10;
   localparam logic [7:0] TX_ENABLE = 8'h20;
   localparam logic [7:0] TXF = 8'h10;
   localparam logic [7:0] RXF = 8'h20;
   localparam logic [IDX_W-1:0] IDX_NONE = 8'h40;

   logic hclk, hresetn, hsel, hwrite, core_sleeping, shift_clk, drive_data;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, data_pin_out, data_pin_oe, irq_request, wake_request;
   logic [8:0] rx;
   int n_mismatch, check_count, cycles;
   wire logic hready = hreadyout;
   // Resolved data pin level
   wire logic data_line = data_pin_oe ? data_pin_out : drive_data;

   sync_serial_slave dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .shift_clk_pin(shift_clk), .data_pin_in(data_line),
      .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .core_sleeping(core_sleeping),
      .irq_request(irq_request), .wake_request(wake_request));

   serial_master_model master (.shift_clk(shift_clk), .drive_data(drive_data), .data_line(data_line));

   // Clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Single AHB-Lite word transfer
   task automatic ahb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {{(32-ADDR_W){1'b0}}, idx, 2'h0};
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= HTRANS_IDLE;
      hsel <= 1'b0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      ahb(1'b1, idx, wd, d);
   endtask

   task automatic rd_chk(input string what, input logic [IDX_W-1:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      ahb(1'b0, idx, 8'h00, d);
      `CHK(what, {24'h0, exp}, d)
      `CHK("hresp", HRESP_OKAY, hresp)
   endtask

   // Frame on the link, then time for the word to settle
   task automatic frame(input logic [8:0] tx, input int nbits);
      master.xfer(tx, nbits, rx);
      repeat (8) @(posedge hclk);
   endtask

   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = HTRANS_IDLE;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      core_sleeping = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      rd_chk("rx_status", IDX_RX_STATUS, 8'h00);
      rd_chk("tx_status", IDX_TX_STATUS, 8'h02);
      rd_chk("enables", IDX_IRQ_EN, RST_IRQ_EN);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'h00);
      wr(IDX_RATE, 8'ha5);
      rd_chk("rate", IDX_RATE, 8'ha5);
      wr(IDX_IRQ_FLAGS, 8'h7f);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_NONE, 8'hff);
      rd_chk("unmapped", IDX_NONE, 8'h00);
      // Slave transmit set up in order, then two words queued while asleep
      wr(IDX_RX_STATUS, SERIAL_PORT_EN);
      wr(IDX_TX_STATUS, SYNC);
      wr(IDX_IRQ_EN, TXF);
      wr(IDX_TX_STATUS, SYNC | TX_ENABLE);
      rd_chk("flags", IDX_IRQ_FLAGS, TXF);
      core_sleeping <= 1'b1;
      wr(IDX_TX_HOLD, 8'h3c);
      wr(IDX_TX_HOLD, 8'ha5);
      repeat (3) @(posedge hclk);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      `CHK("wake", 1'b0, wake_request)
      `CHK("oe", 1'b1, data_pin_oe)
      frame(9'h000, 8);
      `CHK("tx_word1", 8'h3c, rx[7:0])
      `CHK("wake", 1'b1, wake_request)
      `CHK("irq", 1'b1, irq_request)
      rd_chk("flags", IDX_IRQ_FLAGS, TXF);
      rd_chk("tx_status", IDX_TX_STATUS, SYNC | TX_ENABLE);
      frame(9'h000, 8);
      `CHK("tx_word2", 8'ha5, rx[7:0])
      rd_chk("tx_status", IDX_TX_STATUS, SYNC | TX_ENABLE | 8'h02);
      // Ninth bit set before the data byte
      wr(IDX_TX_STATUS, SYNC | TX_ENABLE | 8'h41);
      wr(IDX_TX_HOLD, 8'h81);
      frame(9'h000, 9);
      `CHK("tx_nine", 9'h181, rx)
      `CHK("oe", 1'b0, data_pin_oe)
      // Receive: single-receive enable alone does nothing
      wr(IDX_TX_STATUS, SYNC);
      wr(IDX_IRQ_EN, RXF);
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | SINGLE_RX_EN);
      frame(9'h05a, 8);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      `CHK("irq", 1'b0, irq_request)
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN);
      frame(9'h05a, 8);
      `CHK("wake", 1'b1, wake_request)
      rd_chk("flags", IDX_IRQ_FLAGS, RXF);
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'h5a);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | 8'h40);
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN | 8'h40);
      frame(9'h1c3, 9);
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN | 8'h41);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'hc3);
      // Four words into a two-deep store
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN);
      for (int i = 1; i <= 4; i++) begin
         frame(9'(i * 8'h11), 8);
      end
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN | 8'h02);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'h11);
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN | 8'h02);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'h22);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_RX_STATUS, SERIAL_PORT_EN);
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN);
      wr(IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN);
      // Clock source set: the pin clock must be ignored
      wr(IDX_TX_STATUS, SYNC | 8'h80);
      frame(9'h077, 8);
      rd_chk("flags", IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_TX_STATUS, SYNC);
      frame(9'h066, 8);
      rd_chk("rx_status", IDX_RX_STATUS, SERIAL_PORT_EN | CONTINUOUS_RX_EN);
      rd_chk("rx_holding", IDX_RX_HOLD, 8'h66);
      finish_test();
   end
endmodule
`default_nettype wire
